// ===== pkg/motion_link_if.sv
// Register link and interrupt pin between host controller and sensor
`timescale 1ns/10ps
interface motion_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic int_pin;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output rdata,
    output ack,
    output int_pin
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input rdata,
    input ack,
    input int_pin
  );
endinterface

// ===== pkg/motion_pkg.sv
// Types and rate table shared by both ends of the motion link
package motion_pkg;
  typedef logic [7:0] reg_addr_t;
  typedef logic [23:0] rate_t;
  typedef enum logic [1:0] {WS_INACTIVE, WS_COUNTING, WS_ACTIVE} wake_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_PARK, HS_ACCESS, HS_RESTORE} host_state_t;

  // Output rate in units of 100 uHz, so half of it is exact
  function automatic rate_t odr_of(input logic [3:0] code);
    rate_t r;
    r = 24'h000000;
    unique case (code)
      4'h8: r = 24'd7810;
      4'h9: r = 24'd15630;
      4'ha: r = 24'd31250;
      4'hb: r = 24'd62500;
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: r = 24'd125000 << code[2:0];
      default: r = 24'h000000;
    endcase
    return r;
  endfunction
endpackage

// ===== pkg/motion_regs.svh
// Register map, field positions, reset values and timing counts of the motion block
// Behaviour
// R1: Host parks run mode before rate/delay/limit writes
// R2: Rate code selects output rate; roll-off half
// R3: Rates of 400Hz and above force full power
// R4: Host never writes zero delay count
// R5: One delay count per detection sample period
// R6: Value 0xca enables actuation test; 0x00 restores
// R7: Limit register resets to a 0.5g change
// R8: Limit counts equal threshold g times sixteen
// R9: Any axis over limit leaves inactive state
// R10: Inactive: new sample against previous starts counting
// R11: Counting: new sample against captured start sample
// R12: Report motion only if every difference stayed above
// R13: Any difference not above stops count, stays inactive
// R14: Wake event always latched internally
// R15: Pulse mode gives exactly one pin pulse
// R16: Latch holds until host reads release register
// R17: Detection rate code 0.781Hz doubling to 100Hz
// R18: Release read clears source and idles pin
// R19: Six axis-direction enables, all set after reset
// R20: Engine runs only while its enable is set
// R21: Qualify events only for enabled axis-directions
`ifndef MOTION_REGS_SVH
`define MOTION_REGS_SVH

// Device register offsets
`define ADDR_WAKE_SOURCE 8'h16
`define ADDR_IRQ_RELEASE 8'h1a
`define ADDR_MAIN_CONTROL 8'h1b
`define ADDR_DETECT_RATE 8'h1d
`define ADDR_PIN_CONTROL 8'h1e
`define ADDR_AXIS_ENABLE 8'h1f
`define ADDR_OUTPUT_RATE 8'h21
`define ADDR_DELAY_COUNT 8'h29
`define ADDR_ACTUATION 8'h3a
`define ADDR_DELTA_LIMIT 8'h6a

// Field positions
`define RUN_MODE_BIT 7
`define PERF_MODE_BIT 6
`define ENGINE_ENABLE_BIT 1
`define PIN_ENABLE_BIT 5
`define PIN_POLARITY_BIT 4
`define PIN_PULSE_BIT 3

// Reset values, limit scale and actuation value
`define LIMIT_COUNTS_PER_G 16
`define RST_MAIN_CONTROL 8'h00
`define RST_DETECT_RATE 8'h00
`define RST_PIN_CONTROL 8'h10
`define RST_AXIS_ENABLE 8'h3f
`define RST_OUTPUT_RATE 8'h02
`define RST_DELAY_COUNT 8'h00
`define RST_ACTUATION 8'h00
`define RST_DELTA_LIMIT 8'(`LIMIT_COUNTS_PER_G / 2)
`define ACTUATION_ON 8'hca

// Timing
`define CLK_HZ 40000000
`define CLK_NS 25
`define WAKE_TOP_HZ 100
`define PULSE_MIN_NS 30000
`define PULSE_CYC ((`PULSE_MIN_NS + `CLK_NS - 1) / `CLK_NS)

// Host APB offsets
`define APB_COMMAND 12'h000
`define APB_STATUS 12'h004

`endif

// ===== rtl/motion_delta_check.sv
// Per axis and direction comparison of sample differences against the limit
`timescale 1ns/10ps
module motion_delta_check #(
  parameter int W = 12
) (
  // Samples, x in the low slice
  input wire logic [3*W-1:0] cur,
  input wire logic [3*W-1:0] base,
  // Limit and direction enables, x- at bit 5 down to z+ at bit 0
  input wire logic [7:0] limit,
  input wire logic [5:0] enable,
  // Qualified hits
  output logic [5:0] hit
);
  // Samples arrive at 16 counts per g so the limit compares directly
  for (genvar a = 0; a < 3; a++) begin : g_axis
    wire signed [W+1:0] d = $signed({{2{cur[a*W+W-1]}}, cur[a*W +: W]})
                          - $signed({{2{base[a*W+W-1]}}, base[a*W +: W]});
    wire signed [W+1:0] lim = $signed({{(W-6){1'b0}}, limit});
    wire pos_over = d > lim; // see R9
    wire neg_over = (-d) > lim; // see R9
    assign hit[5-2*a] = neg_over & enable[5-2*a]; // see R21
    assign hit[4-2*a] = pos_over & enable[4-2*a]; // see R21
  end
endmodule

// ===== rtl/motion_device.sv
// Sensor end: configuration registers, wake-up engine and interrupt pin
`timescale 1ns/10ps
`include "motion_regs.svh"
module motion_device #(
  parameter int W = 12,
  parameter int WAKE_TOP_CYC = `CLK_HZ / `WAKE_TOP_HZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the host
  motion_link_if.dev link,
  // High-pass filtered samples, 16 counts per g
  input wire logic [W-1:0] x_sample,
  input wire logic [W-1:0] y_sample,
  input wire logic [W-1:0] z_sample,
  // Configuration state for the sensing path
  output motion_pkg::rate_t odr_rate,
  output motion_pkg::rate_t lpf_rate,
  output logic full_power,
  output logic self_test_on,
  output logic run_mode,
  // Wake event, one cycle
  output logic wake_pulse
);
  import motion_pkg::*;

  logic [7:0] main_reg;
  logic [7:0] detect_reg;
  logic [7:0] pin_reg;
  logic [7:0] axis_reg;
  logic [7:0] rate_reg;
  logic [7:0] delay_reg;
  logic [7:0] act_reg;
  logic [7:0] limit_reg;
  logic [5:0] source_reg;
  logic latch_reg;
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic int_pin_reg;
  logic [31:0] tick_cnt_reg;
  logic [7:0] count_reg;
  logic [10:0] pulse_reg;
  logic [3*W-1:0] prev_reg;
  logic [3*W-1:0] ref_reg;
  rate_t odr_reg;
  logic full_power_reg;
  logic self_test_reg;
  wake_state_t state_reg;
  wake_state_t state_next;
  logic [7:0] rd_mux;

  // Link decode; ack guards against taking one request twice
  wire take = link.req & ~ack_reg;
  wire wr = take & link.we;
  wire rd = take & ~link.we;
  wire release_rd = rd & (link.addr == `ADDR_IRQ_RELEASE); // see R16 see R18

  function automatic logic wr_to(input reg_addr_t a);
    return wr & (link.addr == a);
  endfunction

  // Configuration registers; the host parks run mode before rewriting rate, delay and limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_reg <= `RST_MAIN_CONTROL;
      detect_reg <= `RST_DETECT_RATE;
      pin_reg <= `RST_PIN_CONTROL;
      axis_reg <= `RST_AXIS_ENABLE; // see R19
      rate_reg <= `RST_OUTPUT_RATE;
      delay_reg <= `RST_DELAY_COUNT;
      act_reg <= `RST_ACTUATION;
      limit_reg <= `RST_DELTA_LIMIT; // see R7 see R8
    end else begin
      if (wr_to(`ADDR_MAIN_CONTROL)) begin
        main_reg <= link.wdata & 8'hca;
      end
      if (wr_to(`ADDR_DETECT_RATE)) begin
        detect_reg <= link.wdata & 8'h07;
      end
      if (wr_to(`ADDR_PIN_CONTROL)) begin
        pin_reg <= link.wdata & 8'h3a;
      end
      if (wr_to(`ADDR_AXIS_ENABLE)) begin
        axis_reg <= link.wdata & 8'h3f;
      end
      if (wr_to(`ADDR_OUTPUT_RATE)) begin
        rate_reg <= link.wdata & 8'h0f;
      end
      if (wr_to(`ADDR_DELAY_COUNT)) begin
        delay_reg <= link.wdata;
      end
      if (wr_to(`ADDR_ACTUATION)) begin
        act_reg <= link.wdata;
      end
      if (wr_to(`ADDR_DELTA_LIMIT)) begin
        limit_reg <= link.wdata;
      end
    end
  end

  // Read selection; unmapped addresses read as zero
  always_comb begin
    case (link.addr)
      `ADDR_WAKE_SOURCE: rd_mux = {2'b00, source_reg};
      `ADDR_MAIN_CONTROL: rd_mux = main_reg;
      `ADDR_DETECT_RATE: rd_mux = detect_reg;
      `ADDR_PIN_CONTROL: rd_mux = pin_reg;
      `ADDR_AXIS_ENABLE: rd_mux = axis_reg;
      `ADDR_OUTPUT_RATE: rd_mux = rate_reg;
      `ADDR_DELAY_COUNT: rd_mux = delay_reg;
      `ADDR_ACTUATION: rd_mux = act_reg;
      `ADDR_DELTA_LIMIT: rd_mux = limit_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= take;
      if (rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;

  // Rate decode and operating mode
  wire [3:0] rate_code = rate_reg[3:0];
  wire fast_rate = (rate_code >= 4'h5) & (rate_code <= 4'h7); // see R3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odr_reg <= 24'h000000;
      full_power_reg <= 1'b0;
      self_test_reg <= 1'b0;
    end else begin
      odr_reg <= odr_of(rate_code); // see R2
      full_power_reg <= main_reg[`PERF_MODE_BIT] | fast_rate; // see R3
      self_test_reg <= (act_reg == `ACTUATION_ON); // see R6
    end
  end

  assign odr_rate = odr_reg;
  assign lpf_rate = {1'b0, odr_reg[23:1]}; // see R2
  assign full_power = full_power_reg;
  assign self_test_on = self_test_reg;
  assign run_mode = main_reg[`RUN_MODE_BIT];

  // Detection tick; the long period makes the slow codes costly in simulation
  wire engine_on = main_reg[`RUN_MODE_BIT] & main_reg[`ENGINE_ENABLE_BIT]; // see R20
  wire [2:0] slow_shift = 3'd7 - detect_reg[2:0];
  wire [31:0] tick_period = 32'(WAKE_TOP_CYC) << slow_shift; // see R17
  wire tick = engine_on & (tick_cnt_reg >= tick_period - 32'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (!engine_on || tick) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'd1;
    end
  end

  // Difference against previous sample while inactive, start sample while counting
  wire [3*W-1:0] cur = {z_sample, y_sample, x_sample};
  wire counting = (state_reg == WS_COUNTING);
  wire [3*W-1:0] base = counting ? ref_reg : prev_reg; // see R10 see R11
  wire [5:0] hit;
  wire any_hit = |hit;

  motion_delta_check #(.W(W)) u_delta (
    .cur(cur),
    .base(base),
    .limit(limit_reg),
    .enable(axis_reg[5:0]),
    .hit(hit)
  );

  // A zero delay is not legal; it behaves like one
  wire [8:0] count_plus = {1'b0, count_reg} + 9'd1;
  wire count_done = count_plus >= {1'b0, delay_reg}; // see R5
  wire wake_event = tick & counting & any_hit & count_done; // see R12

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      WS_INACTIVE: begin
        if (tick && any_hit) begin
          state_next = WS_COUNTING; // see R9 see R10
        end
      end
      WS_COUNTING: begin
        if (tick && !any_hit) begin
          state_next = WS_INACTIVE; // see R13
        end else if (wake_event) begin
          state_next = WS_ACTIVE;
        end
      end
      WS_ACTIVE: begin
        if (release_rd) begin
          state_next = WS_INACTIVE;
        end
      end
    endcase
    if (!engine_on) begin
      state_next = WS_INACTIVE; // see R20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= WS_INACTIVE;
      count_reg <= 8'h00;
      prev_reg <= '0;
      ref_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (tick) begin
        prev_reg <= cur;
        count_reg <= counting ? count_plus[7:0] : 8'h00; // see R5
      end
      if (tick && !counting) begin
        ref_reg <= cur; // see R11
      end
    end
  end

  // Latch and source: a new event wins over a release in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= 1'b0;
      source_reg <= 6'h00;
    end else begin
      latch_reg <= wake_event | (latch_reg & ~release_rd); // see R14 see R16
      if (wake_event) begin
        source_reg <= hit;
      end else if (release_rd) begin
        source_reg <= 6'h00; // see R18
      end
    end
  end

  // Pulse runs once per event; the latch still holds until release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= 11'h000;
    end else if (wake_event) begin
      pulse_reg <= 11'(`PULSE_CYC); // see R15
    end else if (release_rd) begin
      pulse_reg <= 11'h000; // see R18
    end else if (pulse_reg != 11'h000) begin
      pulse_reg <= pulse_reg - 11'd1;
    end
  end

  wire pin_active = pin_reg[`PIN_PULSE_BIT] ? (pulse_reg != 11'h000) : latch_reg; // see R15
  wire pin_high = pin_reg[`PIN_POLARITY_BIT];
  wire pin_level = (pin_reg[`PIN_ENABLE_BIT] & pin_active) ? pin_high : ~pin_high; // see R18

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pin_reg <= 1'b0;
    end else begin
      int_pin_reg <= pin_level;
    end
  end

  assign link.int_pin = int_pin_reg;
  assign wake_pulse = wake_event;
endmodule

// ===== rtl/motion_host.sv
// Host end: APB command registers driving the sensor register link
`timescale 1ns/10ps
`include "motion_regs.svh"
module motion_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the sensor
  motion_link_if.host link
);
  import motion_pkg::*;

  host_state_t state_reg;
  reg_addr_t cmd_addr_reg;
  logic [7:0] cmd_data_reg;
  logic cmd_we_reg;
  logic [7:0] shadow_reg;
  logic [7:0] rdata_reg;
  logic refused_reg;

  wire access = psel & penable;
  wire sel_cmd = (paddr == `APB_COMMAND);
  wire sel_status = (paddr == `APB_STATUS);
  wire busy = (state_reg != HS_IDLE);
  wire cmd_wr = access & pwrite & sel_cmd & ~busy;
  wire [7:0] new_addr = pwdata[7:0];
  wire [7:0] new_data = pwdata[15:8];
  wire new_we = pwdata[16];
  wire zero_delay = new_we & (new_addr == `ADDR_DELAY_COUNT) & (new_data == 8'h00); // see R4
  wire guarded = (new_addr == `ADDR_OUTPUT_RATE) | (new_addr == `ADDR_DELAY_COUNT)
               | (new_addr == `ADDR_DELTA_LIMIT);
  wire park = new_we & guarded & shadow_reg[`RUN_MODE_BIT]; // see R1
  wire cmd_guarded = (cmd_addr_reg == `ADDR_OUTPUT_RATE)
                   | (cmd_addr_reg == `ADDR_DELAY_COUNT)
                   | (cmd_addr_reg == `ADDR_DELTA_LIMIT);

  // Zero-wait slave; a command while busy is flagged, not queued
  assign pready = 1'b1;
  assign pslverr = access & ((~sel_cmd & ~sel_status) | (pwrite & sel_cmd & busy));
  assign prdata = sel_status ? {15'h0000, link.int_pin, rdata_reg, 6'h00, refused_reg, busy}
                             : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= HS_IDLE;
      cmd_addr_reg <= 8'h00;
      cmd_data_reg <= 8'h00;
      cmd_we_reg <= 1'b0;
      shadow_reg <= `RST_MAIN_CONTROL;
      rdata_reg <= 8'h00;
      refused_reg <= 1'b0;
    end else begin
      if (cmd_wr && zero_delay) begin
        refused_reg <= 1'b1; // see R4
      end else if (access && pwrite && sel_status && pwdata[1]) begin
        refused_reg <= 1'b0;
      end
      if (cmd_wr && !zero_delay) begin
        cmd_addr_reg <= new_addr;
        cmd_data_reg <= new_data;
        cmd_we_reg <= new_we;
        state_reg <= park ? HS_PARK : HS_ACCESS; // see R1
      end
      if (link.ack) begin
        unique case (state_reg)
          HS_PARK: state_reg <= HS_ACCESS;
          HS_ACCESS: begin
            if (!cmd_we_reg) begin
              rdata_reg <= link.rdata; // see R16
            end
            if (cmd_we_reg && cmd_addr_reg == `ADDR_MAIN_CONTROL) begin
              shadow_reg <= cmd_data_reg;
            end
            state_reg <= (cmd_we_reg && cmd_guarded && shadow_reg[`RUN_MODE_BIT])
                         ? HS_RESTORE : HS_IDLE;
          end
          HS_RESTORE: state_reg <= HS_IDLE;
          HS_IDLE: state_reg <= HS_IDLE;
        endcase
      end
    end
  end

  // Parking writes run mode low, restore writes the shadow back
  wire main_step = (state_reg == HS_PARK) | (state_reg == HS_RESTORE);
  assign link.req = busy;
  assign link.we = main_step | cmd_we_reg;
  assign link.addr = main_step ? `ADDR_MAIN_CONTROL : cmd_addr_reg;
  assign link.wdata = (state_reg == HS_PARK) ? (shadow_reg & ~8'h80) // see R1
                    : main_step ? shadow_reg : cmd_data_reg;
endmodule

// ===== testbench/motion_asserts.sv
// Checks on the link and interrupt pin between host and sensor
`timescale 1ns/10ps
`include "motion_regs.svh"
module motion_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic int_pin
);
  localparam int PULSE = `PULSE_CYC;
  logic run_reg;
  logic [7:0] pin_reg;
  logic [11:0] cnt_reg;
  logic done_reg;
  wire take = req && !ack;
  wire wr = take && we;
  wire rel = take && !we && addr == `ADDR_IRQ_RELEASE;
  wire act = pin_reg[5] && int_pin == pin_reg[4];
  wire pulse = pin_reg[5] && pin_reg[3];
  wire guarded = addr == `ADDR_OUTPUT_RATE || addr == `ADDR_DELAY_COUNT
    || addr == `ADDR_DELTA_LIMIT;
  // Shadows follow the wire only, so no design state is peeked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      pin_reg <= `RST_PIN_CONTROL;
      cnt_reg <= 12'h000;
      done_reg <= 1'b0;
    end else begin
      if (wr && addr == `ADDR_MAIN_CONTROL) run_reg <= wdata[`RUN_MODE_BIT];
      if (wr && addr == `ADDR_PIN_CONTROL) pin_reg <= wdata;
      cnt_reg <= act ? cnt_reg + 12'h001 : 12'h000;
      if (rel) done_reg <= 1'b0;
      else if (pulse && !act && cnt_reg != 12'h000) done_reg <= 1'b1;
    end
  end
  sequence s_rel;
    rel ##1 ack;
  endsequence
  sequence s_pulse_end;
    (pulse && act) ##1 (pulse && !act);
  endsequence
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ack_follows: assert property (take |=> ack)
    else $error("link request not answered next cycle");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_holds: assert property (take |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  a_rdata_holds: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  // Pin is registered, so it idles one cycle after the answer
  a_release_idles: assert property (s_rel |-> rdata == 8'h00 ##1 !act)
    else $error("release read left pin active");
  a_latch_holds: assert property (act && !pulse && !rel && !$past(rel) |=> act)
    else $error("latched pin dropped without release");
  a_pulse_length: assert property (s_pulse_end |-> cnt_reg == PULSE)
    else $error("pin pulse of wrong length");
  a_pulse_once: assert property (done_reg |-> !act)
    else $error("second pulse for one event");
  a_park_first: assert property (wr && guarded |-> !run_reg)
    else $error("guarded write while running");
  a_no_zero_delay: assert property (wr && addr == `ADDR_DELAY_COUNT |-> wdata != 8'h00)
    else $error("zero delay count sent");
endmodule

// ===== testbench/testbench.sv
// Bench driving both ends of the motion link over APB and samples
`timescale 1ns/10ps
`include "motion_regs.svh"
module testbench;
  import motion_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [11:0] s [3] = '{default: 12'h000};
  rate_t odr;
  rate_t lpf;
  logic fp, st_on, run, wp;
  logic [31:0] seed = 32'hdd76;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int nwake = 0;
  int tw = 0;
  int lim;
  motion_link_if link_if();
  motion_device #(.W(12), .WAKE_TOP_CYC(4)) motion_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link_if.dev), .x_sample(s[0]), .y_sample(s[1]), .z_sample(s[2]), .odr_rate(odr),
    .lpf_rate(lpf), .full_power(fp), .self_test_on(st_on), .run_mode(run), .wake_pulse(wp));
  motion_host motion_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if.host));
  motion_asserts motion_asserts_inst (.pclk(pclk), .presetn(presetn), .req(link_if.req),
    .we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata),
    .ack(link_if.ack), .int_pin(link_if.int_pin));
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wp === 1'b1) begin
      nwake <= nwake + 1;
      tw <= cyc;
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic rate_t exp_odr(input logic [3:0] c);
    case (c)
      4'h8: return 24'h001e82;
      4'h9: return 24'h003d0e;
      4'ha: return 24'h007a12;
      4'hb: return 24'h00f424;
      default: return c[3] ? 24'h000000 : 24'h01e848 << c[2:0];
    endcase
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results();
    $display("failures=%0d compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      failures++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One host command, then poll until the host is idle
  task cmd(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] st);
    logic e;
    int k;
    apb(1'b1, `APB_COMMAND, {15'h0000, w, d, a}, st, e);
    k = 0;
    do begin
      apb(1'b0, `APB_STATUS, 32'h0, st, e);
      k++;
    end while (st[0] !== 1'b0 && k < 50);
    if (st[0] !== 1'b0) begin
      failures++;
      results();
    end
  endtask
  // Random axis, direction, rate and step; delay count is 3
  task trial(input logic dis, input logic [7:0] mn, input logic [7:0] pin,
    input logic back, input logic hit);
    logic [31:0] st;
    logic [7:0] b;
    logic neg;
    int a, d, tk, t0, nw, rc;
    a = int'(rnd() % 3);
    neg = rnd() % 2 != 0;
    rc = 4 + int'(rnd() % 4);
    tk = 4 << (7 - rc);
    d = lim + 1 + int'(rnd() % 20);
    b = 8'h01 << (4 - 2 * a + neg);
    cmd(1'b1, `ADDR_DETECT_RATE, 8'(rc), st);
    cmd(1'b1, `ADDR_AXIS_ENABLE, dis ? 8'h3f & ~b : 8'h3f, st);
    cmd(1'b1, `ADDR_PIN_CONTROL, pin, st);
    cmd(1'b1, `ADDR_MAIN_CONTROL, mn, st);
    nw = nwake;
    t0 = cyc;
    s[a] <= s[a] + 12'(neg ? -d : d);
    // Reference is the trigger sample, so a held step alone must drop out
    if (!back) begin
      repeat (tk) @(posedge pclk);
      s[a] <= s[a] + 12'(neg ? -d : d);
    end
    repeat (5 * tk) @(posedge pclk);
    chk(nwake - nw, hit);
    if (hit) chk(tw - t0 >= 3 * tk && tw - t0 <= 4 * tk + 2, 1'b1);
    if (pin[3]) repeat (1300) @(posedge pclk);
    cmd(1'b0, `ADDR_WAKE_SOURCE, 8'h00, st);
    chk(st[15:8], hit ? b : 8'h00);
    chk(st[16], hit && !pin[3]);
    cmd(1'b0, `ADDR_IRQ_RELEASE, 8'h00, st);
    cmd(1'b0, `ADDR_WAKE_SOURCE, 8'h00, st);
    chk(st[16:8], 9'h000);
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    failures++;
    results();
  end
  initial begin
    logic [31:0] st;
    logic e;
    logic [7:0] av [4];
    reg_addr_t ta [6];
    logic [7:0] tv [6];
    ta = '{`ADDR_AXIS_ENABLE, `ADDR_OUTPUT_RATE, `ADDR_DELAY_COUNT, `ADDR_ACTUATION,
      `ADDR_DELTA_LIMIT, `ADDR_PIN_CONTROL};
    tv = '{8'h3f, 8'h02, 8'h00, 8'h00, 8'h08, 8'h10};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cmd(1'b0, ta[i], 8'h00, st);
      chk(st[15:8], tv[i]);
    end
    apb(1'b0, 12'h008, 32'h0, st, e);
    chk(e, 1'b1);
    // Running, so rate writes must go through a park
    cmd(1'b1, `ADDR_MAIN_CONTROL, 8'h80, st);
    for (int c = 0; c < 16; c++) begin
      cmd(1'b1, `ADDR_OUTPUT_RATE, 8'(c), st);
      chk(odr, exp_odr(4'(c)));
      chk(lpf, exp_odr(4'(c)) >> 1);
      chk(fp, c >= 5 && c <= 7);
    end
    chk(run, 1'b1);
    cmd(1'b1, `ADDR_MAIN_CONTROL, 8'hc0, st);
    chk(fp, 1'b1);
    cmd(1'b1, `ADDR_MAIN_CONTROL, 8'h80, st);
    av = '{8'hca, 8'h00, 8'hca, 8'(rnd()) | 8'h01};
    for (int i = 0; i < 4; i++) begin
      cmd(1'b1, `ADDR_ACTUATION, av[i], st);
      chk(st_on, i % 2 == 0);
    end
    cmd(1'b1, `ADDR_DELAY_COUNT, 8'h00, st);
    chk(st[1], 1'b1);
    apb(1'b1, `APB_STATUS, 32'h2, st, e);
    cmd(1'b1, `ADDR_DELAY_COUNT, 8'h03, st);
    chk(st[1], 1'b0);
    lim = 1 + int'(rnd() % 15);
    cmd(1'b1, `ADDR_DELTA_LIMIT, 8'(lim), st);
    cmd(1'b0, `ADDR_DELTA_LIMIT, 8'h00, st);
    chk(st[15:8], 8'(lim));
    repeat (3) trial(1'b0, 8'h82, 8'h30, 1'b0, 1'b1);
    trial(1'b0, 8'h82, 8'h38, 1'b0, 1'b1);
    trial(1'b0, 8'h82, 8'h30, 1'b1, 1'b0);
    trial(1'b1, 8'h82, 8'h30, 1'b0, 1'b0);
    trial(1'b0, 8'h80, 8'h30, 1'b0, 1'b0);
    results();
  end
endmodule
